// ==== rtl/qdsl_pkg.sv ====
// shared constants for the quad converter serial load link
package qdsl_pkg;
    // frame geometry
    localparam int FRAME_BITS = 24; // plain command frame
    localparam int CHECK_BITS = 8; // appended check code
    localparam int FRAME_BITS_CHECKED = FRAME_BITS + CHECK_BITS; // frame with check code
    localparam int COUNT_W = 6; // bit counter width, saturates
    // command field positions
    localparam int RW_BIT = 23;
    localparam int DEV_ADDR_MSB = 22;
    localparam int DEV_ADDR_LSB = 21;
    localparam int REG_SEL_MSB = 20;
    localparam int REG_SEL_LSB = 18;
    localparam int CH_SEL_MSB = 17;
    localparam int CH_SEL_LSB = 16;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 4;
    localparam logic [2:0] REG_SEL_DAC_DATA = 3'h0; // channel data register select
    // converter structure
    localparam int CHANNELS = 4;
    localparam int CODE_BITS = 12;
    localparam int THERM_BITS = 15; // segment switches from the top four code bits
    localparam int LADDER_BITS = 8; // binary ladder switches
    localparam int CURRENT_BITS = 15; // output current in microamps
    // output ranges and their spans
    typedef enum logic [1:0] {
        QDSL_RANGE_0_20 = 2'h0,
        QDSL_RANGE_0_24 = 2'h1,
        QDSL_RANGE_4_20 = 2'h2
    } qdsl_range_t;
    localparam logic [14:0] SPAN_0_20_UA = 15'h4E20; // 20 mA
    localparam logic [14:0] SPAN_0_24_UA = 15'h5DC0; // 24 mA
    localparam logic [14:0] SPAN_4_20_UA = 15'h3E80; // 16 mA
    localparam logic [14:0] OFFSET_4_20_UA = 15'h0FA0; // 4 mA
    // host timing
    localparam int CLOCK_MHZ = 100;
    localparam int STARTUP_US = 100; // wait after reset before any write
    localparam int STARTUP_CYCLES = STARTUP_US * CLOCK_MHZ;
    localparam int SCLK_HALF_CYCLES = 2; // 25 MHz serial clock
    localparam int SYNC_GAP_CYCLES = 8; // frame sync high time between frames
    localparam int LOAD_LOW_CYCLES = 4; // width of the load pulse
endpackage

// ==== rtl/qdsl_link_if.sv ====
// serial link between host and converter
`timescale 1ns/1ps
interface qdsl_link_if;
    logic sclk; // serial clock, made by the host
    logic sync_n; // frame sync, active low
    logic sdi; // serial data, msb first
    logic load_outputs_n; // output load strobe, active low
    // host drives everything
    modport host (
        output sclk,
        output sync_n,
        output sdi,
        output load_outputs_n
    );
    // converter only listens
    modport device (
        input sclk,
        input sync_n,
        input sdi,
        input load_outputs_n
    );
endinterface

// ==== rtl/qdsl_sync2.sv ====
// two flip-flop level synchroniser
`timescale 1ns/1ps
module qdsl_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg; // first stage, read only by second
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg; // second stage
    logic [WIDTH-1:0] sync_next;

    // next values
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
        if (rst) begin
            meta_next = INIT;
            sync_next = INIT;
        end
    end

    // registers
    always_ff @(posedge clock) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;
endmodule

// ==== rtl/qdsl_device.sv ====
// converter end: serial input, channel update and switch decode
`timescale 1ns/1ps
// Overview of operation
// - 24-bit frames shifted in msb first
// - data sampled on serial clock falling edge
// - check code extends frame to 32 bits
// - codes are straight unsigned binary
// - load low: channel updates at sync rise
// - host holds load high for simultaneous update
// - load high: first write per channel kept
// - discarded writes still show on readback
// - load falling after sync high updates all channels holding a code
// - outputs tristate from power on
// - host waits 100 us after reset
// - top four bits to fifteen thermometer switches
// - low eight bits drive ladder switches
// - three ranges, current scales with code, plus a 4 mA offset in the 4-20 range
// - frame fields: rw, address, register, channel, data
// - code sits in frame bits 15 to 4
module qdsl_device (
    input wire logic clock,
    input wire logic rst,
    qdsl_link_if.device link,
    input wire logic device_addr_bit1,
    input wire logic device_addr_bit0,
    input wire logic frame_check_enable,
    input wire logic [1:0] output_range,
    output logic [qdsl_pkg::CHANNELS-1:0] channel_output_enable,
    output logic [qdsl_pkg::CHANNELS-1:0][qdsl_pkg::THERM_BITS-1:0] segment_switch,
    output logic [qdsl_pkg::CHANNELS-1:0][qdsl_pkg::LADDER_BITS-1:0] ladder_switch,
    output logic [qdsl_pkg::CHANNELS-1:0][qdsl_pkg::CURRENT_BITS-1:0] channel_current_output,
    output logic [qdsl_pkg::CHANNELS-1:0][qdsl_pkg::CODE_BITS-1:0] readback_code,
    output logic frame_accepted,
    output logic frame_rejected
);
    localparam int CH = qdsl_pkg::CHANNELS;
    localparam int CB = qdsl_pkg::CODE_BITS;
    localparam int CW = qdsl_pkg::COUNT_W;
    localparam int SW = qdsl_pkg::FRAME_BITS_CHECKED;

    // ---- link domain, clocked by the serial clock ----
    logic [SW-1:0] shift_reg; // input shift register
    logic [SW-1:0] shift_next;
    logic [CW-1:0] count_reg; // bits seen in this frame
    logic [CW-1:0] count_next;
    logic start_reg; // set while sync high, marks the next bit as first

    // shift and count next values
    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        if (!link.sync_n) begin
            shift_next = {shift_reg[SW-2:0], link.sdi};
            if (start_reg) begin
                count_next = CW'(1);
            end else if (count_reg != {CW{1'b1}}) begin
                count_next = count_reg + CW'(1);
            end
        end
    end

    // sampling on the falling serial clock edge
    always_ff @(negedge link.sclk) begin
        shift_reg <= shift_next;
        count_reg <= count_next;
    end

    // first-bit marker, preset while sync is high
    always_ff @(negedge link.sclk or posedge link.sync_n) begin
        if (link.sync_n) begin
            start_reg <= 1'b1;
        end else begin
            start_reg <= 1'b0;
        end
    end

    // ---- system domain ----
    logic [3:0] pins_s; // synchronised sync, load and address pins
    logic sync_s;
    logic load_s;
    logic [1:0] addr_s;

    // pins pass two flops before use
    qdsl_sync2 #(
        .WIDTH(4),
        .INIT(4'hC)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .async_in({link.sync_n, link.load_outputs_n, device_addr_bit1, device_addr_bit0}),
        .sync_out(pins_s)
    );
    assign sync_s = pins_s[3];
    assign load_s = pins_s[2];
    assign addr_s = pins_s[1:0];

    logic sync_d_reg; // previous synced sync
    logic sync_d_next;
    logic load_d_reg; // previous synced load
    logic load_d_next;
    logic [CH-1:0][CB-1:0] dac_reg; // code driving each channel
    logic [CH-1:0][CB-1:0] dac_next;
    logic [CH-1:0][CB-1:0] held_reg; // first code caught while load high
    logic [CH-1:0][CB-1:0] held_next;
    logic [CH-1:0] pend_reg; // channel has a held code
    logic [CH-1:0] pend_next;
    logic [CH-1:0][CB-1:0] rb_reg; // last written code, for readback
    logic [CH-1:0][CB-1:0] rb_next;
    logic [CH-1:0] en_reg; // output leaves tristate
    logic [CH-1:0] en_next;
    logic [CH-1:0][qdsl_pkg::THERM_BITS-1:0] therm_reg;
    logic [CH-1:0][qdsl_pkg::THERM_BITS-1:0] therm_next;
    logic [CH-1:0][qdsl_pkg::LADDER_BITS-1:0] ladder_reg;
    logic [CH-1:0][qdsl_pkg::LADDER_BITS-1:0] ladder_next;
    logic [CH-1:0][qdsl_pkg::CURRENT_BITS-1:0] cur_reg;
    logic [CH-1:0][qdsl_pkg::CURRENT_BITS-1:0] cur_next;
    logic acc_reg; // frame acted on
    logic acc_next;
    logic rej_reg; // frame of wrong length, a read, for another address or another register
    logic rej_next;

    // decode and update next values
    always_comb begin
        logic frame_end;
        logic load_fall;
        logic len_ok;
        logic is_write;
        logic [qdsl_pkg::FRAME_BITS-1:0] word;
        logic [1:0] ch;
        logic [CB-1:0] code;
        logic [14:0] span;
        logic [14:0] offs;
        logic [26:0] prod;
        // defaults so no path leaves a local unassigned
        word = '0;
        len_ok = 1'b0;
        span = '0;
        offs = '0;
        prod = '0;
        frame_end = sync_s & ~sync_d_reg;
        load_fall = ~load_s & load_d_reg;
        // shift and count are frozen while sync is high, so reading them here is safe
        if (frame_check_enable) begin
            word = shift_reg[SW-1:qdsl_pkg::CHECK_BITS];
            len_ok = count_reg == CW'(qdsl_pkg::FRAME_BITS_CHECKED);
        end else begin
            word = shift_reg[qdsl_pkg::FRAME_BITS-1:0];
            len_ok = count_reg == CW'(qdsl_pkg::FRAME_BITS);
        end
        is_write = frame_end & len_ok & ~word[qdsl_pkg::RW_BIT]
            & (word[qdsl_pkg::DEV_ADDR_MSB:qdsl_pkg::DEV_ADDR_LSB] == addr_s)
            & (word[qdsl_pkg::REG_SEL_MSB:qdsl_pkg::REG_SEL_LSB] == qdsl_pkg::REG_SEL_DAC_DATA);
        ch = word[qdsl_pkg::CH_SEL_MSB:qdsl_pkg::CH_SEL_LSB];
        code = word[qdsl_pkg::CODE_MSB:qdsl_pkg::CODE_LSB];
        sync_d_next = sync_s;
        load_d_next = load_s;
        dac_next = dac_reg;
        held_next = held_reg;
        pend_next = pend_reg;
        rb_next = rb_reg;
        en_next = en_reg;
        acc_next = is_write;
        rej_next = frame_end & ~is_write;
        // simultaneous load of every held code
        if (load_fall && sync_s) begin
            for (int c = 0; c < CH; c++) begin
                if (pend_reg[c]) begin
                    dac_next[c] = held_reg[c];
                    en_next[c] = 1'b1;
                    pend_next[c] = 1'b0;
                end
            end
        end
        // channel data write
        if (is_write) begin
            rb_next[ch] = code;
            if (!load_s) begin
                dac_next[ch] = code;
                en_next[ch] = 1'b1;
            end else if (!pend_next[ch]) begin
                held_next[ch] = code;
                pend_next[ch] = 1'b1;
            end
        end
        // range scaling
        case (qdsl_pkg::qdsl_range_t'(output_range))
            qdsl_pkg::QDSL_RANGE_0_20: begin
                span = qdsl_pkg::SPAN_0_20_UA;
                offs = '0;
            end
            qdsl_pkg::QDSL_RANGE_0_24: begin
                span = qdsl_pkg::SPAN_0_24_UA;
                offs = '0;
            end
            qdsl_pkg::QDSL_RANGE_4_20: begin
                span = qdsl_pkg::SPAN_4_20_UA;
                offs = qdsl_pkg::OFFSET_4_20_UA;
            end
            default: begin
                span = qdsl_pkg::SPAN_0_20_UA;
                offs = '0;
            end
        endcase
        // switch decode and current per channel
        for (int c = 0; c < CH; c++) begin
            for (int i = 0; i < qdsl_pkg::THERM_BITS; i++) begin
                therm_next[c][i] = dac_next[c][CB-1:CB-4] > 4'(i);
            end
            ladder_next[c] = dac_next[c][qdsl_pkg::LADDER_BITS-1:0];
            prod = 27'(span) * 27'(dac_next[c]);
            cur_next[c] = prod[26:CB] + offs;
        end
        if (rst) begin
            sync_d_next = 1'b1;
            load_d_next = 1'b1;
            dac_next = '0;
            held_next = '0;
            pend_next = '0;
            rb_next = '0;
            en_next = '0;
            therm_next = '0;
            ladder_next = '0;
            cur_next = '0;
            acc_next = 1'b0;
            rej_next = 1'b0;
        end
    end

    // system registers
    always_ff @(posedge clock) begin
        sync_d_reg <= sync_d_next;
        load_d_reg <= load_d_next;
        dac_reg <= dac_next;
        held_reg <= held_next;
        pend_reg <= pend_next;
        rb_reg <= rb_next;
        en_reg <= en_next;
        therm_reg <= therm_next;
        ladder_reg <= ladder_next;
        cur_reg <= cur_next;
        acc_reg <= acc_next;
        rej_reg <= rej_next;
    end

    assign channel_output_enable = en_reg;
    assign segment_switch = therm_reg;
    assign ladder_switch = ladder_reg;
    assign channel_current_output = cur_reg;
    assign readback_code = rb_reg;
    assign frame_accepted = acc_reg;
    assign frame_rejected = rej_reg;
endmodule

// ==== rtl/qdsl_host.sv ====
// host end: frames commands and drives the load strobe
`timescale 1ns/1ps
module qdsl_host #(
    parameter int STARTUP_CYCLES = qdsl_pkg::STARTUP_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    qdsl_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [qdsl_pkg::FRAME_BITS-1:0] cmd_word,
    input wire logic [qdsl_pkg::CHECK_BITS-1:0] cmd_check,
    input wire logic check_enable,
    input wire logic load_hold,
    input wire logic load_request
);
    localparam int TW = $clog2(STARTUP_CYCLES + 1);
    localparam int SW = qdsl_pkg::FRAME_BITS_CHECKED;
    localparam int CW = qdsl_pkg::COUNT_W;

    typedef enum logic [2:0] {
        ST_STARTUP = 3'h0, // post-reset wait
        ST_IDLE = 3'h1, // ready for a command
        ST_SHIFT = 3'h2, // frame on the link
        ST_GAP = 3'h3, // sync high between frames
        ST_LOAD = 3'h4 // load strobe low
    } qdsl_host_state_t;

    qdsl_host_state_t state_reg;
    qdsl_host_state_t state_next;
    logic [TW-1:0] timer_reg; // down counter for every wait
    logic [TW-1:0] timer_next;
    logic [SW-1:0] frame_reg; // bits still to send, msb on the pin
    logic [SW-1:0] frame_next;
    logic [CW-1:0] bits_reg; // falling edges left
    logic [CW-1:0] bits_next;
    logic sclk_reg;
    logic sclk_next;
    logic sync_n_reg;
    logic sync_n_next;
    logic sdi_reg;
    logic sdi_next;
    logic load_n_reg;
    logic load_n_next;
    logic ready_reg;
    logic ready_next;

    // sequencer next values
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        frame_next = frame_reg;
        bits_next = bits_reg;
        sclk_next = sclk_reg;
        sync_n_next = sync_n_reg;
        sdi_next = sdi_reg;
        load_n_next = load_n_reg;
        ready_next = ready_reg;
        case (state_reg)
            ST_STARTUP: begin
                if (timer_reg != '0) begin
                    timer_next = timer_reg - TW'(1);
                end else begin
                    state_next = ST_IDLE;
                    ready_next = 1'b1;
                end
            end
            ST_IDLE: begin
                load_n_next = load_hold;
                if (cmd_valid) begin
                    if (check_enable) begin
                        frame_next = {cmd_word, cmd_check};
                        bits_next = CW'(qdsl_pkg::FRAME_BITS_CHECKED);
                    end else begin
                        frame_next = {cmd_word, qdsl_pkg::CHECK_BITS'(0)};
                        bits_next = CW'(qdsl_pkg::FRAME_BITS);
                    end
                    sdi_next = frame_next[SW-1];
                    sync_n_next = 1'b0;
                    sclk_next = 1'b1;
                    timer_next = TW'(qdsl_pkg::SCLK_HALF_CYCLES - 1);
                    ready_next = 1'b0;
                    state_next = ST_SHIFT;
                end else if (load_request) begin
                    load_n_next = 1'b0;
                    timer_next = TW'(qdsl_pkg::LOAD_LOW_CYCLES - 1);
                    ready_next = 1'b0;
                    state_next = ST_LOAD;
                end
            end
            ST_SHIFT: begin
                if (timer_reg != '0) begin
                    timer_next = timer_reg - TW'(1);
                end else begin
                    timer_next = TW'(qdsl_pkg::SCLK_HALF_CYCLES - 1);
                    if (sclk_reg) begin
                        sclk_next = 1'b0; // falling edge, device samples
                        bits_next = bits_reg - CW'(1);
                    end else if (bits_reg == '0) begin
                        sclk_next = 1'b1;
                        sync_n_next = 1'b1;
                        timer_next = TW'(qdsl_pkg::SYNC_GAP_CYCLES - 1);
                        state_next = ST_GAP;
                    end else begin
                        sclk_next = 1'b1;
                        frame_next = {frame_reg[SW-2:0], 1'b0};
                        sdi_next = frame_reg[SW-2];
                    end
                end
            end
            ST_GAP, ST_LOAD: begin
                if (timer_reg != '0) begin
                    timer_next = timer_reg - TW'(1);
                end else begin
                    load_n_next = load_hold;
                    ready_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (rst) begin
            state_next = ST_STARTUP;
            timer_next = TW'(STARTUP_CYCLES - 1);
            frame_next = '0;
            bits_next = '0;
            sclk_next = 1'b1;
            sync_n_next = 1'b1;
            sdi_next = 1'b0;
            load_n_next = 1'b1;
            ready_next = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge clock) begin
        state_reg <= state_next;
        timer_reg <= timer_next;
        frame_reg <= frame_next;
        bits_reg <= bits_next;
        sclk_reg <= sclk_next;
        sync_n_reg <= sync_n_next;
        sdi_reg <= sdi_next;
        load_n_reg <= load_n_next;
        ready_reg <= ready_next;
    end

    assign link.sclk = sclk_reg;
    assign link.sync_n = sync_n_reg;
    assign link.sdi = sdi_reg;
    assign link.load_outputs_n = load_n_reg;
    assign cmd_ready = ready_reg;
endmodule

// ==== tb/qdsl_link_checker.sv ====
// wire-level assertions for the serial load link
`timescale 1ns/1ps
module qdsl_link_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdi,
    input wire logic load_outputs_n
);
    logic sclk_reg; // serial clock one cycle ago
    logic sclk_next;
    logic [5:0] falls_reg; // clock falls in the open frame
    logic [5:0] falls_next;
    // count serial clock falls while sync is low
    always_comb begin
        sclk_next = rst ? 1'b1 : sclk;
        falls_next = (sync_n || rst) ? 6'h00 : falls_reg + {5'h00, sclk_reg & ~sclk};
    end
    always_ff @(posedge clock) begin
        sclk_reg <= sclk_next;
        falls_reg <= falls_next;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // low half of one serial clock period
    sequence low_half;
        !sclk ##1 sclk;
    endsequence
    // frame opens with the clock still high
    sequence open_high;
        sclk ##1 sclk;
    endsequence
    a_sclk_idle_high: assert property (sync_n |-> sclk)
        else $error("serial clock moves outside a frame");
    a_fall_in_frame: assert property ($fell(sclk) |-> !sync_n)
        else $error("clock fall with sync high");
    a_sclk_low_half: assert property ($fell(sclk) |=> low_half)
        else $error("serial clock low phase wrong");
    a_sdi_held_low: assert property (!sclk |-> $stable(sdi))
        else $error("data moved while clock low");
    a_frame_bit_count: assert property ($rose(sync_n) |->
        (falls_reg == 6'h18 || falls_reg == 6'h20))
        else $error("frame length not 24 or 32");
    a_sync_gap_min: assert property ($rose(sync_n) |-> sync_n[*6])
        else $error("sync gap too short");
    a_load_pulse_min: assert property ($fell(load_outputs_n) |-> !load_outputs_n[*4])
        else $error("load pulse too short");
    a_load_steady_frame: assert property ((!sync_n && !$fell(sync_n))
        |-> $stable(load_outputs_n))
        else $error("load strobe moved inside a frame");
    a_frame_opens_high: assert property ($fell(sync_n) |-> open_high)
        else $error("frame opened without clock high");
endmodule

// ==== tb/quad_dac_serial_load_tb.sv ====
// bench: host and converter ends joined across the link
`timescale 1ns/1ps
module quad_dac_serial_load_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [23:0] cmd_word = 24'h000000;
    logic [7:0] cmd_check = 8'h00;
    logic check_enable = 1'b0;
    logic load_hold = 1'b0;
    logic load_request = 1'b0;
    logic addr1 = 1'b1; // converter strap pins
    logic addr0 = 1'b0;
    logic frame_check_enable = 1'b0;
    logic [1:0] output_range = 2'h0;
    logic [3:0] out_en;
    logic [3:0][14:0] segment;
    logic [3:0][7:0] ladder;
    logic [3:0][14:0] current;
    logic [3:0][11:0] readback;
    logic accepted;
    logic rejected;
    logic [31:0] wire_bits = 32'h00000000; // bits seen on the link
    int wire_count = 0;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [11:0] code_a [4]; // first write per channel
    logic [11:0] code_b [4]; // later discarded write
    qdsl_link_if link();
    qdsl_host #(.STARTUP_CYCLES(20)) i_qdsl_host (.clock(clock), .rst(rst), .link(link),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .cmd_check(cmd_check), .check_enable(check_enable), .load_hold(load_hold),
        .load_request(load_request));
    qdsl_device i_qdsl_device (.clock(clock), .rst(rst), .link(link),
        .device_addr_bit1(addr1), .device_addr_bit0(addr0),
        .frame_check_enable(frame_check_enable), .output_range(output_range),
        .channel_output_enable(out_en), .segment_switch(segment), .ladder_switch(ladder),
        .channel_current_output(current), .readback_code(readback),
        .frame_accepted(accepted), .frame_rejected(rejected));
    qdsl_link_checker i_qdsl_link_checker (.clock(clock), .rst(rst), .sclk(link.sclk),
        .sync_n(link.sync_n), .sdi(link.sdi), .load_outputs_n(link.load_outputs_n));
    // clock source
    initial begin
        forever #5 clock = ~clock;
    end
    // capture data on falling serial clock inside frames
    always @(negedge link.sclk) begin
        if (link.sync_n === 1'b0) begin
            wire_bits <= {wire_bits[30:0], link.sdi};
            wire_count <= wire_count + 1;
        end
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            print_verdict();
        end
    end
    // one comparison
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // expected current in microamps, floor
    function automatic logic [14:0] exp_cur(input logic [11:0] c);
        logic [14:0] span;
        logic [26:0] prod;
        span = (output_range == 2'h1) ? qdsl_pkg::SPAN_0_24_UA :
            (output_range == 2'h2) ? qdsl_pkg::SPAN_4_20_UA : qdsl_pkg::SPAN_0_20_UA;
        prod = {12'h000, span} * {15'h0000, c};
        return prod[26:12] + ((output_range == 2'h2) ? qdsl_pkg::OFFSET_4_20_UA : 15'h0000);
    endfunction
    // write frame: flag, address, register, channel, code, filler
    function automatic logic [23:0] frame(input logic rw, input logic [1:0] ad,
        input logic [2:0] rs, input logic [1:0] ch, input logic [11:0] c);
        return {rw, ad, rs, ch, c, 4'($urandom)};
    endfunction
    task automatic wait_ready;
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (cmd_ready !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: host never ready", $time);
        end
    endtask
    // send one frame, return {rejected, accepted}
    task automatic send(input logic [23:0] w, input logic chk, output logic [1:0] res);
        int n;
        wait_ready();
        cmd_word = w;
        cmd_check = 8'($urandom);
        check_enable = chk;
        cmd_valid = 1'b1;
        wire_count = 0;
        @(posedge clock);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (accepted !== 1'b1 && rejected !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1;
            n++;
        end
        res = {rejected, accepted};
        check(32'(wire_count), chk ? 32'h20 : 32'h18, "bits on wire");
        check(chk ? wire_bits : {8'h00, wire_bits[23:0]},
            chk ? {w, cmd_check} : {8'h00, w}, "wire order");
    endtask
    // channel outputs and readback
    task automatic expect_ch(input logic [1:0] c, input logic [11:0] oc, input logic [11:0] rc);
        logic [14:0] seg;
        for (int i = 0; i < 15; i++) seg[i] = oc[11:8] > 4'(i);
        check(32'(segment[c]), 32'(seg), "segment");
        check(32'(ladder[c]), 32'(oc[7:0]), "ladder");
        check(32'(current[c]), 32'(exp_cur(oc)), "current");
        check(32'(readback[c]), 32'(rc), "readback");
        check(32'(out_en[c]), 32'h1, "enable");
    endtask
    // main sequence
    initial begin
        logic [1:0] res;
        logic [11:0] code;
        void'($urandom(73624));
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        check(32'(out_en), 32'h0, "tristate at start");
        // individual update over every range, check byte off and on
        for (int k = 0; k < 16; k++) begin
            code = (k == 4) ? 12'hFFF : (k == 5) ? 12'h000 : 12'($urandom);
            output_range = 2'(k >> 2);
            frame_check_enable = k[0];
            send(frame(1'b0, {addr1, addr0}, qdsl_pkg::REG_SEL_DAC_DATA, 2'(k), code), k[0], res);
            check(32'(res), 32'h1, "write taken");
            expect_ch(2'(k), code, code);
            code_a[2'(k)] = code; // last individual code per channel
        end
        // simultaneous update: first write held, later only readback
        load_hold = 1'b1;
        frame_check_enable = 1'b0;
        for (int c = 0; c < 4; c++) begin
            code = code_a[c]; // output still from the individual phase
            code_a[c] = 12'($urandom);
            code_b[c] = 12'($urandom);
            send(frame(1'b0, {addr1, addr0}, 3'h0, 2'(c), code_a[c]), 1'b0, res);
            check(32'(res), 32'h1, "held write taken");
            send(frame(1'b0, {addr1, addr0}, 3'h0, 2'(c), code_b[c]), 1'b0, res);
            check(32'(res), 32'h1, "late write taken");
            expect_ch(2'(c), code, code_b[c]);
        end
        wait_ready();
        load_request = 1'b1;
        @(posedge clock);
        #1;
        load_request = 1'b0;
        repeat (10) @(posedge clock);
        #1;
        for (int c = 0; c < 4; c++) expect_ch(2'(c), code_a[c], code_b[c]);
        // refused frames: read flag, address, register, length
        load_hold = 1'b0;
        for (int k = 0; k < 4; k++) begin
            send(frame(k == 0, {addr1, addr0 ^ (k == 1)}, (k == 2) ? 3'h5 : 3'h0, 2'h0,
                12'($urandom)), k == 3, res);
            check(32'(res), 32'h2, "frame refused");
            expect_ch(2'h0, code_a[0], code_b[0]);
        end
        print_verdict();
    end
endmodule
